// *** dual_8bit_timer_control_test.sv ***
// Self-checking testbench of the dual 8-bit timer control block.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dual_8bit_timer_control_test;
  import tdc_pkg::*;
  logic       clk;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       low_freq_clock;
  logic       timer_a_pin;
  logic       timer_b_pin;
  logic       timer_a_out;
  logic       timer_b_out;
  int         checks;
  int         miscompares;
  logic [7:0] v;
  logic [7:0] w;
  int         n;
  int         m;

  tdc_top i_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .low_freq_clock(low_freq_clock),
    .timer_a_pin(timer_a_pin), .timer_b_pin(timer_b_pin),
    .timer_a_out(timer_a_out), .timer_b_out(timer_b_out)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  // Slow pulses keep each edge well clear of the synchroniser latency.
  task automatic pulses(input bit pin, input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      if (pin) begin
        timer_a_pin <= 1'b1;
        timer_b_pin <= 1'b1;
      end else begin
        low_freq_clock <= 1'b1;
      end
      repeat (4) @(posedge clk);
      if (pin) begin
        timer_a_pin <= 1'b0;
        timer_b_pin <= 1'b0;
      end else begin
        low_freq_clock <= 1'b0;
      end
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask

  // Cycles from one change of the chosen output to the next.
  task automatic span(input bit b, output int cnt);
    logic s;
    int   k;
    k = 0;
    s = b ? timer_b_out : timer_a_out;
    while ((b ? timer_b_out : timer_a_out) === s && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    cnt = 0;
    s = b ? timer_b_out : timer_a_out;
    while ((b ? timer_b_out : timer_a_out) === s && cnt < 2000) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask

  task automatic t_reset;
    rchk(TDC_OFS_CTL_A, 8'h00);
    rchk(TDC_OFS_CTL_B, 8'h00);
    rchk(TDC_OFS_PW_A, 8'hff);
    rchk(TDC_OFS_PER_A, 8'hff);
    rchk(TDC_OFS_STATUS, 8'h00);
    rchk(TDC_OFS_CNT_A, 8'h00);
    rchk(8'h20, 8'h00);
  endtask

  task automatic t_clocks;
    logic [2:0] sel [4] = '{3'h5, 3'h3, 3'h2, 3'h1};
    int         sh [4] = '{1, 3, 5, 7};
    wr(TDC_OFS_CTL_A, 8'h68);
    rd(TDC_OFS_CNT_A, v);
    rd(TDC_OFS_CNT_A, w);
    `CHK(8'(w - v), 8'h02)
    wr(TDC_OFS_CTL_A, 8'h60);
    repeat (2) @(posedge clk);
    rchk(TDC_OFS_CNT_A, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(TDC_OFS_CTL_A, {1'b0, sel[i], 4'h8});
      repeat (8 << sh[i]) @(posedge clk);
      rd(TDC_OFS_CNT_A, v);
      `CHK(v >= 8'h07 && v <= 8'h09, 1'b1)
      wr(TDC_OFS_CTL_A, {1'b0, sel[i], 4'h0});
    end
    wr(TDC_OFS_CTL_A, 8'h48);
    pulses(1'b0, 5);
    rchk(TDC_OFS_CNT_A, 8'h05);
    wr(TDC_OFS_CTL_A, 8'h40);
    wr(TDC_OFS_CTL_A, 8'h78);
    wr(TDC_OFS_CTL_B, 8'h78);
    pulses(1'b1, 5);
    rchk(TDC_OFS_CNT_A, 8'h05);
    rchk(TDC_OFS_CNT_B, 8'h05);
    wr(TDC_OFS_CTL_A, 8'h70);
    wr(TDC_OFS_CTL_B, 8'h70);
    wr(TDC_OFS_CFG, 8'h01);
    wr(TDC_OFS_CTL_A, 8'h88);
    pulses(1'b0, 16);
    rchk(TDC_OFS_CNT_A, 8'h02);
    `CHK(timer_a_out, 1'b1)
    wr(TDC_OFS_CTL_A, 8'h80);
    // Slow mode stops the divided taps, here DIV1; the undivided clock stays selectable.
    wr(TDC_OFS_CFG, 8'h02);
    wr(TDC_OFS_CTL_A, 8'h58);
    repeat (8) @(posedge clk);
    rchk(TDC_OFS_CNT_A, 8'h00);
    wr(TDC_OFS_CTL_A, 8'h50);
    wr(TDC_OFS_CFG, 8'h00);
  endtask

  task automatic t_protect;
    wr(TDC_OFS_CTL_A, 8'h68);
    wr(TDC_OFS_PER_A, 8'h10);
    rchk(TDC_OFS_PER_A, 8'hff);
    wr(TDC_OFS_PW_A, 8'h10);
    rchk(TDC_OFS_PW_A, 8'hff);
    wr(TDC_OFS_CTL_A, 8'h0a);
    rchk(TDC_OFS_CTL_A, 8'h68);
    wr(TDC_OFS_CTL_A, 8'h60);
    rchk(TDC_OFS_CTL_A, 8'h60);
    wr(TDC_OFS_CTL_A, 8'hea);
    rchk(TDC_OFS_CTL_A, 8'hea);
    wr(TDC_OFS_PW_A, 8'h40);
    rchk(TDC_OFS_PW_A, 8'h40);
    span(1'b0, n);
    // Measure the segment that follows at once, so the two add to a period.
    m = 0;
    v[0] = timer_a_out;
    while (timer_a_out === v[0] && m < 2000) begin
      @(posedge clk);
      #1;
      m++;
    end
    `CHK(n + m, 256)
    wr(TDC_OFS_CTL_A, 8'he2);
  endtask

  task automatic t_modes;
    wr(TDC_OFS_PER_A, 8'h03);
    wr(TDC_OFS_CTL_A, 8'h69);
    span(1'b0, n);
    `CHK(n, 4)
    wr(TDC_OFS_CTL_A, 8'h61);
    wr(TDC_OFS_CTL_A, 8'h63);
    wr(TDC_OFS_PER_A, 8'h05);
    wr(TDC_OFS_PER_B, 8'h00);
    wr(TDC_OFS_CTL_B, 8'h09);
    span(1'b1, n);
    `CHK(n, 6)
    rd(TDC_OFS_STATUS, v);
    `CHK(v[4], 1'b1)
    wr(TDC_OFS_CTL_B, 8'h01);
    wr(TDC_OFS_CTL_A, 8'h60);
  endtask

  task automatic wrap_up;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    sys_rst        = 1'b1;
    reg_addr       = 8'h00;
    reg_wdata      = 8'h00;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    low_freq_clock = 1'b0;
    timer_a_pin    = 1'b0;
    timer_b_pin    = 1'b0;
    checks         = 0;
    miscompares    = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_clocks();
    t_protect();
    t_modes();
    wrap_up();
  end
endmodule // dual_8bit_timer_control_test

// *** tdc_chk.sv ***
// Concurrent checks on the register port and the timer A output of the timer pair.
`timescale 1ns/10ps
module tdc_chk
  import tdc_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       low_freq_clock,
  input wire logic       timer_a_pin,
  input wire logic       timer_b_pin,
  input wire logic       timer_a_out,
  input wire logic       timer_b_out
);
  logic [7:0] a_q;
  logic [7:0] b_q;
  wire        wr_a     = reg_wr && reg_addr == TDC_OFS_CTL_A;
  wire        rd_cnt_a = reg_rd && reg_addr == TDC_OFS_CNT_A;
  wire        run6     = a_q[3] && a_q[6:4] == TDC_CK_HIGH &&
                         a_q[2:0] != TDC_MODE_CASC;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Shadows of both control registers; a write made while running only
  // moves the start bit, so the other fields keep their old value.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_q <= TDC_CTL_RST;
    end else if (wr_a) begin
      a_q <= a_q[3] ? {a_q[7:4], reg_wdata[3], a_q[2:0]} : reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      b_q <= TDC_CTL_RST;
    end else if (reg_wr && reg_addr == TDC_OFS_CTL_B) begin
      b_q <= b_q[3] ? {b_q[7:4], reg_wdata[3], b_q[2:0]} : reg_wdata;
    end
  end

  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == TDC_RD_ZERO)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (
    reg_rd && (reg_addr < TDC_OFS_CTL_A || reg_addr > TDC_OFS_STATUS)
    |=> reg_rdata == TDC_RD_ZERO)
    else $error("unmapped read returned data");
  a_ctl_a_fields: assert property (
    reg_rd && reg_addr == TDC_OFS_CTL_A |=> reg_rdata == a_q)
    else $error("control A fields changed while running");
  a_ctl_b_fields: assert property (
    reg_rd && reg_addr == TDC_OFS_CTL_B |=> reg_rdata == b_q)
    else $error("control B fields changed while running");
  a_stop_clears: assert property (
    rd_cnt_a && !a_q[3] && !b_q[3] && !$past(a_q[3]) && !$past(b_q[3])
    |=> reg_rdata == TDC_RD_ZERO)
    else $error("stopped counter not cleared");
  a_status_stop: assert property (
    reg_rd && reg_addr == TDC_OFS_STATUS && !a_q[3] && !b_q[3]
    |=> reg_rdata[1:0] == 2'h0)
    else $error("status shows a run while stopped");
  a_start_load: assert property (
    wr_a && !a_q[3] && reg_wdata[3] && reg_wdata[6:4] == TDC_CK_DIV11 &&
    reg_wdata[2:0] != TDC_MODE_CASC
    |-> ##2 timer_a_out == $past(reg_wdata[7], 2))
    else $error("output not loaded at start");
  a_count_step: assert property (
    rd_cnt_a && run6 && $past(run6) ##2 rd_cnt_a && run6
    |=> reg_rdata == 8'($past(reg_rdata, 2) + 8'h02) ||
        reg_rdata < 8'h02)
    else $error("counter did not advance once per clock");
endmodule // tdc_chk

bind tdc_top tdc_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .low_freq_clock(low_freq_clock),
  .timer_a_pin(timer_a_pin), .timer_b_pin(timer_b_pin),
  .timer_a_out(timer_a_out), .timer_b_out(timer_b_out)
);

// *** tdc_clksel.sv ***
// Prescaler and source clock selection for both timers.
`timescale 1ns/10ps
module tdc_clksel
  import tdc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       low_freq_clock,
  input  wire logic       timer_a_pin,
  input  wire logic       timer_b_pin,
  input  wire logic       divider_seven_select,
  input  wire logic       slow_mode,
  input  wire logic [2:0] sel_a,
  input  wire logic [2:0] sel_b,
  output logic            tick_a,
  output logic            tick_b
);

  logic [TDC_PRE_W-1:0] pre_q;
  logic [2:0]           lf_sync_q;
  logic [2:0]           lf_div_q;
  logic [1:0][2:0]      pin_sync_q;
  logic                 lf_edge;
  logic                 lf_div8;
  logic [1:0]           pin_edge;
  logic [1:0][2:0]      sel;
  logic [1:0]           tick;

  function automatic logic tap(input logic [TDC_PRE_W-1:0] pre,
                               input logic [TDC_PRE_W-1:0] mask);
    tap = ((pre & mask) == mask);
  endfunction

  // Divided taps of the high-frequency clock do not exist in slow mode.
  function automatic logic pick(input logic [2:0]           s,
                                input logic [TDC_PRE_W-1:0] pre,
                                input logic                 lf8,
                                input logic                 lf1,
                                input logic                 pin,
                                input logic                 dv7,
                                input logic                 slow);
    pick = 1'b0;
    case (s)
      TDC_CK_DIV11: pick = (!slow && !dv7) ? tap(pre, TDC_MASK_D11) : lf8;
      TDC_CK_DIV7:  pick = !slow && tap(pre, TDC_MASK_D7);
      TDC_CK_DIV5:  pick = !slow && tap(pre, TDC_MASK_D5);
      TDC_CK_DIV3:  pick = !slow && tap(pre, TDC_MASK_D3);
      TDC_CK_LOW:   pick = lf1;
      TDC_CK_DIV1:  pick = !slow && tap(pre, TDC_MASK_D1);
      TDC_CK_HIGH:  pick = 1'b1;
      default:      pick = pin;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 11'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lf_sync_q <= 3'h0;
    end else begin
      lf_sync_q <= {lf_sync_q[1:0], low_freq_clock};
    end
  end

  assign lf_edge = lf_sync_q[1] && !lf_sync_q[2];
  assign lf_div8 = lf_edge && (lf_div_q == TDC_LF_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lf_div_q <= 3'h0;
    end else if (lf_edge) begin
      lf_div_q <= lf_div_q + 3'h1;
    end
  end

  assign sel[0] = sel_a;
  assign sel[1] = sel_b;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_src
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pin_sync_q[i] <= 3'h0;
        end else begin
          pin_sync_q[i] <= {pin_sync_q[i][1:0],
                            (i == 0) ? timer_a_pin : timer_b_pin};
        end
      end
      assign pin_edge[i] = pin_sync_q[i][1] && !pin_sync_q[i][2];
      assign tick[i] = pick(sel[i], pre_q, lf_div8, lf_edge, pin_edge[i],
                            divider_seven_select, slow_mode);
    end
  endgenerate

  assign tick_a = tick[0];
  assign tick_b = tick[1];

endmodule // tdc_clksel

// *** tdc_counter.sv ***
// One 8-bit up-counter stage of the timer pair.
`timescale 1ns/10ps
module tdc_counter
  import tdc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       clear,
  output logic [7:0]      count,
  output logic            carry
);

  logic [7:0] count_q;

  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      count_q <= TDC_RD_ZERO;
    end else if (tick) begin
      if (clear) begin
        count_q <= TDC_RD_ZERO;
      end else begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  assign count = count_q;
  assign carry = run && tick && !clear && (count_q == TDC_CNT_MAX);

endmodule // tdc_counter

// *** tdc_pkg.sv ***
// Constants shared by the dual 8-bit timer control block.
package tdc_pkg;

  // Register map, at the offsets the register port decodes.
  localparam logic [7:0] TDC_OFS_CTL_A   = 8'h15;
  localparam logic [7:0] TDC_OFS_CTL_B   = 8'h16;
  localparam logic [7:0] TDC_OFS_PW_A    = 8'h17;
  localparam logic [7:0] TDC_OFS_PW_B    = 8'h18;
  localparam logic [7:0] TDC_OFS_PER_A   = 8'h19;
  localparam logic [7:0] TDC_OFS_PER_B   = 8'h1a;
  localparam logic [7:0] TDC_OFS_CNT_A   = 8'h1b;
  localparam logic [7:0] TDC_OFS_CNT_B   = 8'h1c;
  localparam logic [7:0] TDC_OFS_CFG     = 8'h1d;
  localparam logic [7:0] TDC_OFS_STATUS  = 8'h1e;

  // Reset values, the zero read value and the counter maximum.
  localparam logic [7:0] TDC_CTL_RST     = 8'h00;
  localparam logic [7:0] TDC_PW_RST      = 8'hff;
  localparam logic [7:0] TDC_PER_RST     = 8'hff;
  localparam logic [1:0] TDC_CFG_RST     = 2'h0;
  localparam logic [7:0] TDC_RD_ZERO     = 8'h00;
  localparam logic [7:0] TDC_CNT_MAX     = 8'hff;

  // Control register fields.
  localparam int TDC_TFF_BIT   = 7;
  localparam int TDC_CK_HI     = 6;
  localparam int TDC_CK_LO     = 4;
  localparam int TDC_START_BIT = 3;
  localparam int TDC_MODE_HI   = 2;
  localparam int TDC_MODE_LO   = 0;

  // Configuration register fields.
  localparam int TDC_CFG_DV7_BIT  = 0;
  localparam int TDC_CFG_SLOW_BIT = 1;

  // Source clock select codes.
  localparam logic [2:0] TDC_CK_DIV11  = 3'h0;
  localparam logic [2:0] TDC_CK_DIV7   = 3'h1;
  localparam logic [2:0] TDC_CK_DIV5   = 3'h2;
  localparam logic [2:0] TDC_CK_DIV3   = 3'h3;
  localparam logic [2:0] TDC_CK_LOW    = 3'h4;
  localparam logic [2:0] TDC_CK_DIV1   = 3'h5;
  localparam logic [2:0] TDC_CK_HIGH   = 3'h6;
  localparam logic [2:0] TDC_CK_PIN    = 3'h7;

  // Operating mode codes.
  localparam logic [2:0] TDC_MODE_PDO  = 3'h1;
  localparam logic [2:0] TDC_MODE_PWM  = 3'h2;
  localparam logic [2:0] TDC_MODE_CASC = 3'h3;

  // Prescaler taps of the high-frequency clock, and the last count of the low-frequency divider.
  localparam int          TDC_PRE_W    = 11;
  localparam logic [10:0] TDC_MASK_D1  = 11'h001;
  localparam logic [10:0] TDC_MASK_D3  = 11'h007;
  localparam logic [10:0] TDC_MASK_D5  = 11'h01f;
  localparam logic [10:0] TDC_MASK_D7  = 11'h07f;
  localparam logic [10:0] TDC_MASK_D11 = 11'h7ff;
  localparam logic [2:0]  TDC_LF_LAST  = 3'h7;

endpackage

// *** tdc_top.sv ***
// Register file and mode control of the dual 8-bit timer pair.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module tdc_top
  import tdc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       low_freq_clock,
  input  wire logic       timer_a_pin,
  input  wire logic       timer_b_pin,
  output logic            timer_a_out,
  output logic            timer_b_out
);

  import tdc_pkg::*;

  logic [7:0]      timer_a_control_q;
  logic [7:0]      timer_b_control_q;
  logic [7:0]      timer_a_pulse_width_q;
  logic [7:0]      timer_b_pulse_width_q;
  logic [7:0]      timer_a_period_q;
  logic [7:0]      timer_b_period_q;
  logic [1:0]      cfg_q;
  logic [7:0]      rdata_q;
  logic [1:0]      run_prev_q;
  logic [1:0]      flop_q;

  logic            cascade;
  logic [1:0][7:0] ctl;
  logic [1:0][7:0] cnt;
  logic [1:0][7:0] per;
  logic [1:0][7:0] pw;
  logic [1:0][2:0] mode;
  logic [1:0]      run;
  logic [1:0]      tff;
  logic [1:0]      src_tick;
  logic [1:0]      cnt_tick;
  logic [1:0]      cnt_clear;
  logic [1:0]      carry;
  logic [1:0]      per_hit;
  logic [1:0]      pw_hit;
  logic [1:0]      wrap_hit;
  logic [1:0]      evt_tick;
  logic            hit16_per;
  logic            hit16_pw;
  logic            wrap16;

  function automatic logic [2:0] mode_of(input logic [7:0] c);
    mode_of = c[TDC_MODE_HI:TDC_MODE_LO];
  endfunction

  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == TDC_MODE_PWM);
  endfunction

  // A control register with its start bit set only accepts a change of that bit, so outside
  // cascade the mode, clock and flip-flop fields cannot be altered under a live count.
  function automatic logic [7:0] ctl_merge(input logic [7:0] old_v,
                                           input logic [7:0] new_v);
    logic [7:0] kept;
    kept = old_v;
    kept[TDC_START_BIT] = new_v[TDC_START_BIT];
    if (old_v[TDC_START_BIT]) begin
      ctl_merge = kept;
    end else begin
      ctl_merge = new_v;
    end
  endfunction

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = reg_wr && (reg_addr == ofs);
  endfunction

  // Mode decode and cascade routing.
  assign cascade = (mode_of(timer_a_control_q) == TDC_MODE_CASC);

  assign ctl[0] = cascade ? timer_b_control_q : timer_a_control_q;
  assign ctl[1] = timer_b_control_q;
  assign per[0] = timer_a_period_q;
  assign per[1] = timer_b_period_q;
  assign pw[0]  = timer_a_pulse_width_q;
  assign pw[1]  = timer_b_pulse_width_q;

  assign hit16_per = ({cnt[1], cnt[0]} == {per[1], per[0]});
  assign hit16_pw  = ({cnt[1], cnt[0]} == {pw[1], pw[0]});
  assign wrap16    = ({cnt[1], cnt[0]} == {TDC_CNT_MAX, TDC_CNT_MAX});

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_eff
      assign mode[i] = mode_of(ctl[i]);
      assign run[i]  = ctl[i][TDC_START_BIT];
      assign tff[i]  = ctl[i][TDC_TFF_BIT];
    end
  endgenerate

  // Clock selection; the upper clock field is unused while cascaded.
  tdc_clksel u_clksel (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .low_freq_clock       (low_freq_clock),
    .timer_a_pin          (timer_a_pin),
    .timer_b_pin          (timer_b_pin),
    .divider_seven_select (cfg_q[TDC_CFG_DV7_BIT]),
    .slow_mode            (cfg_q[TDC_CFG_SLOW_BIT]),
    .sel_a                (timer_a_control_q[TDC_CK_HI:TDC_CK_LO]),
    .sel_b                (timer_b_control_q[TDC_CK_HI:TDC_CK_LO]),
    .tick_a               (src_tick[0]),
    .tick_b               (src_tick[1])
  );

  // In cascade the upper stage counts lower-stage carries, and also
  // takes the lower stage's tick when the joint period match clears both.
  assign per_hit[0] = cascade ? hit16_per : (cnt[0] == per[0]);
  assign per_hit[1] = cascade ? hit16_per : (cnt[1] == per[1]);
  assign pw_hit[0]  = cascade ? hit16_pw : (cnt[0] == pw[0]);
  assign pw_hit[1]  = cascade ? hit16_pw : (cnt[1] == pw[1]);
  assign wrap_hit[0] = cascade ? wrap16 : (cnt[0] == TDC_CNT_MAX);
  assign wrap_hit[1] = cascade ? wrap16 : (cnt[1] == TDC_CNT_MAX);

  assign cnt_clear[0] = !is_pwm(mode[0]) && per_hit[0];
  assign cnt_clear[1] = !is_pwm(mode[1]) && per_hit[1];
  assign cnt_tick[0]  = src_tick[0];
  assign cnt_tick[1]  = cascade ? (carry[0] || (src_tick[0] && cnt_clear[1]))
                                : src_tick[1];
  assign evt_tick[0]  = src_tick[0] && run[0];
  assign evt_tick[1]  = (cascade ? src_tick[0] : src_tick[1]) && run[1];

  generate
    for (i = 0; i < 2; i++) begin : g_cnt
      tdc_counter u_counter (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (run[i]),
        .tick    (cnt_tick[i]),
        .clear   (cnt_clear[i]),
        .count   (cnt[i]),
        .carry   (carry[i])
      );

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          run_prev_q[i] <= 1'b0;
        end else begin
          run_prev_q[i] <= run[i];
        end
      end

      // The flip-flop is preset from its control bit at each start. The
      // lower stage's output holds while the pair counts as one.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          flop_q[i] <= 1'b0;
        end else if (i == 0 && cascade) begin
          flop_q[i] <= flop_q[i];
        end else if (run[i] && !run_prev_q[i]) begin
          flop_q[i] <= tff[i];
        end else if (evt_tick[i]) begin
          if (mode[i] == TDC_MODE_PDO && per_hit[i]) begin
            flop_q[i] <= !flop_q[i];
          end else if (is_pwm(mode[i]) && wrap_hit[i]) begin
            flop_q[i] <= tff[i];
          end else if (is_pwm(mode[i]) && pw_hit[i]) begin
            flop_q[i] <= !flop_q[i];
          end
        end
      end
    end
  endgenerate

  assign timer_a_out = flop_q[0];
  assign timer_b_out = flop_q[1];

  // Control registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_a_control_q <= TDC_CTL_RST;
    end else if (wr_hit(TDC_OFS_CTL_A)) begin
      timer_a_control_q <= ctl_merge(timer_a_control_q, reg_wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_b_control_q <= TDC_CTL_RST;
    end else if (wr_hit(TDC_OFS_CTL_B)) begin
      timer_b_control_q <= ctl_merge(timer_b_control_q, reg_wdata);
    end
  end

  // Period writes during a run are dropped rather than trusted, so a
  // stray write cannot move a match point past the live count.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_a_period_q <= TDC_PER_RST;
      timer_b_period_q <= TDC_PER_RST;
    end else begin
      if (wr_hit(TDC_OFS_PER_A) && !run[0]) begin
        timer_a_period_q <= reg_wdata;
      end
      if (wr_hit(TDC_OFS_PER_B) && !run[1]) begin
        timer_b_period_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_a_pulse_width_q <= TDC_PW_RST;
      timer_b_pulse_width_q <= TDC_PW_RST;
    end else begin
      if (wr_hit(TDC_OFS_PW_A) && (!run[0] || is_pwm(mode[0]))) begin
        timer_a_pulse_width_q <= reg_wdata;
      end
      if (wr_hit(TDC_OFS_PW_B) && (!run[1] || is_pwm(mode[1]))) begin
        timer_b_pulse_width_q <= reg_wdata;
      end
    end
  end

  // Operating condition: divider select and slow mode. In slow mode the
  // undivided high clock is left selectable for warm-up use only.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= TDC_CFG_RST;
    end else if (wr_hit(TDC_OFS_CFG)) begin
      cfg_q <= reg_wdata[1:0];
    end
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge clk) begin
    if (sys_rst || !reg_rd) begin
      rdata_q <= TDC_RD_ZERO;
    end else if (reg_addr == TDC_OFS_CTL_A) begin
      rdata_q <= timer_a_control_q;
    end else if (reg_addr == TDC_OFS_CTL_B) begin
      rdata_q <= timer_b_control_q;
    end else if (reg_addr == TDC_OFS_PW_A) begin
      rdata_q <= timer_a_pulse_width_q;
    end else if (reg_addr == TDC_OFS_PW_B) begin
      rdata_q <= timer_b_pulse_width_q;
    end else if (reg_addr == TDC_OFS_PER_A) begin
      rdata_q <= timer_a_period_q;
    end else if (reg_addr == TDC_OFS_PER_B) begin
      rdata_q <= timer_b_period_q;
    end else if (reg_addr == TDC_OFS_CNT_A) begin
      rdata_q <= cnt[0];
    end else if (reg_addr == TDC_OFS_CNT_B) begin
      rdata_q <= cnt[1];
    end else if (reg_addr == TDC_OFS_CFG) begin
      rdata_q <= {6'h00, cfg_q};
    end else if (reg_addr == TDC_OFS_STATUS) begin
      rdata_q <= {3'h0, cascade, flop_q, run};
    end else begin
      rdata_q <= TDC_RD_ZERO;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // tdc_top
